// ===== inc/vrs_dec_if.sv
// Carrier between the register side and the reference decoder.
// Assumes both ends sit in the same clock domain; it carries no clock.
`timescale 1ns/1ns
`default_nettype none
interface vrs_dec_if;
   logic [7:0] ctrl;
   logic [vrs_pkg::SEL_W-1:0] sel;
   logic cmp1_ladder;
   logic cmp2_ladder;
   logic div_current;
   vrs_pkg::vrs_src_type cmp_pos;
   vrs_pkg::vrs_src_type cmp_neg;
   vrs_pkg::vrs_src_type conv_pos;
   vrs_pkg::vrs_src_type conv_neg;
   vrs_pkg::vrs_pin_role_type pin_role;
   logic pos_pin_ref;
   logic [vrs_pkg::FRAC_W-1:0] frac;

   modport ctrl_mp (
      output ctrl, sel,
      input cmp1_ladder, cmp2_ladder, div_current, cmp_pos, cmp_neg,
      input conv_pos, conv_neg, pin_role, pos_pin_ref, frac
   );
   modport dec_mp (
      input ctrl, sel,
      output cmp1_ladder, cmp2_ladder, div_current, cmp_pos, cmp_neg,
      output conv_pos, conv_neg, pin_role, pos_pin_ref, frac
   );
endinterface : vrs_dec_if
`default_nettype wire

// ===== inc/vrs_pkg.sv
// Constants, field positions and enumerations for the reference selector.
// Assumes an 8-bit register port with a two-bit word address.
package vrs_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam int unsigned ADDR_W = 2;
   localparam int unsigned DATA_W = 8;
   localparam logic [1:0] CTRL_ADDR = 2'h0;
   localparam logic [1:0] SEL_ADDR = 2'h1;
   localparam logic [1:0] STAT_ADDR = 2'h2;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [4:0] SEL_RESET = 5'h00;
   localparam logic [7:0] READ_IDLE = 8'h00;

   // Fields of reference_control.
   localparam int unsigned POWER_BIT = 7;
   localparam int unsigned PIN_OUT_BIT = 6;
   localparam int unsigned LOW_RANGE_BIT = 5;
   localparam int unsigned EXT_SRC_BIT = 4;
   localparam int unsigned TAP_MSB = 3;
   localparam int unsigned TAP_W = 4;

   // Fields of reference_route.
   localparam int unsigned SEL_W = 5;
   localparam int unsigned CMP1_BIT = 0;
   localparam int unsigned CMP2_BIT = 1;
   localparam int unsigned FIXED_EN_BIT = 2;
   localparam int unsigned CONV_POS_BIT = 3;
   localparam int unsigned CONV_NEG_BIT = 4;

   // Fields of reference_status.
   localparam int unsigned ST_DIV_BIT = 0;
   localparam int unsigned ST_FIXED_BIT = 1;
   localparam int unsigned ST_ROLE_LSB = 2;
   localparam int unsigned ST_ROLE_MSB = 3;
   localparam int unsigned ST_POS_PIN_BIT = 4;
   localparam int unsigned ST_POWER_BIT = 5;

   // ***************************************************************
   // Ladder fraction, as a numerator over 96
   // ***************************************************************
   localparam int unsigned FRAC_W = 7;
   localparam logic [6:0] LOW_MUL = 7'h04;
   localparam logic [6:0] HIGH_BASE = 7'h18;
   localparam logic [6:0] HIGH_MUL = 7'h03;

   // ***************************************************************
   // Enumerations
   // ***************************************************************
   typedef enum logic [1:0] {
      PIN_IO = 2'b00,
      PIN_LADDER_OUT = 2'b01,
      PIN_NEG_REF = 2'b10
   } vrs_pin_role_type;

   typedef enum logic {
      SRC_RAIL = 1'b0,
      SRC_PIN = 1'b1
   } vrs_src_type;

endpackage : vrs_pkg

// ===== rtl/vrs_ref_decode.sv
// Combinational decode of reference routing from the control bits.
// Assumes the caller registers every result it drives out of the block.
`timescale 1ns/1ns
`default_nettype none
module vrs_ref_decode (
   // Control bits in, routing out.
   vrs_dec_if.dec_mp dec
);

   // Picks the pin or the rail for one reference from its select bit.
   function automatic vrs_pkg::vrs_src_type src_of(input logic use_pin);
      src_of = use_pin ? vrs_pkg::SRC_PIN : vrs_pkg::SRC_RAIL;
   endfunction : src_of

   logic pin_out;
   logic ext_src;
   logic conv_neg_ext;
   logic [3:0] tap;

   // ***************************************************************
   // Field extraction
   // ***************************************************************
   assign pin_out = dec.ctrl[vrs_pkg::PIN_OUT_BIT];
   assign ext_src = dec.ctrl[vrs_pkg::EXT_SRC_BIT];
   assign conv_neg_ext = dec.sel[vrs_pkg::CONV_NEG_BIT];
   assign tap = dec.ctrl[vrs_pkg::TAP_MSB:0];

   // Comparator multiplexers; either one on keeps the divider biased.
   assign dec.cmp1_ladder = dec.sel[vrs_pkg::CMP1_BIT]; // R1
   assign dec.cmp2_ladder = dec.sel[vrs_pkg::CMP2_BIT]; // R2
   assign dec.div_current = dec.cmp1_ladder | dec.cmp2_ladder; // R3

   // Comparator rails; the ladder on the shared pin steals its minus side.
   assign dec.cmp_pos = src_of(ext_src); // R4
   assign dec.cmp_neg = src_of(ext_src & ~(pin_out & ~conv_neg_ext)); // R4

   // Converter rails are independent of the comparator selection.
   assign dec.conv_pos = src_of(dec.sel[vrs_pkg::CONV_POS_BIT]); // R5
   assign dec.conv_neg = src_of(conv_neg_ext); // R5

   // Shared pin: ladder output has priority unless the converter needs it.
   always_comb begin
      if (pin_out && !conv_neg_ext) begin
         dec.pin_role = vrs_pkg::PIN_LADDER_OUT; // R6
      end else if (conv_neg_ext || ext_src) begin
         dec.pin_role = vrs_pkg::PIN_NEG_REF; // R6
      end else begin
         dec.pin_role = vrs_pkg::PIN_IO;
      end
   end

   // Positive pin is a reference whenever anything consumes it.
   assign dec.pos_pin_ref = ext_src | dec.sel[vrs_pkg::CONV_POS_BIT];

   // Ladder fraction in 96ths so both ranges are exact integers.
   always_comb begin
      if (dec.ctrl[vrs_pkg::LOW_RANGE_BIT]) begin
         dec.frac = 7'(tap) * vrs_pkg::LOW_MUL; // R8 R10
      end else begin
         dec.frac = vrs_pkg::HIGH_BASE + 7'(tap) * vrs_pkg::HIGH_MUL; // R10
      end
   end

endmodule : vrs_ref_decode
`default_nettype wire

// ===== rtl/vrs_reference_select.sv
// Register file and registered reference routing for the comparator
// and converter references.
// Assumes a synchronous register port and synchronous oscillator status.
// Contract
// R1 - Comparator one bit selects ladder, enables divider.
// R2 - Comparator two bit selects ladder, enables divider.
// R3 - Both bits clear turns divider current off.
// R4 - Comparator rails follow source bit and pin use.
// R5 - Converter rails follow its two external bits.
// R6 - Shared pin role: ladder out, ref, or I/O.
// R7 - Power bit switches the ladder circuit.
// R8 - Range bit set means low ladder range.
// R9 - Source bit picks pins or supply for ladder.
// R10 - Tap field gives v/24 or 1/4+v/32.
// R11 - Control register fully readable, writable, resets zero.
// R12 - Fixed reference on by bit or fast oscillator.
// R13 - Decoded outputs change on the writing edge.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module vrs_reference_select (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Register port.
   input wire logic [vrs_pkg::ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Oscillator status.
   input wire logic fast_internal_oscillator_i,
   // Ladder control.
   output logic ladder_power_on_o,
   output logic ladder_low_range_o,
   output logic ladder_external_source_o,
   output logic [vrs_pkg::TAP_W-1:0] ladder_tap_select_o,
   output logic [vrs_pkg::FRAC_W-1:0] ladder_frac_num_o,
   output logic divider_current_o,
   // Reference routing.
   output logic cmp_one_ladder_select_o,
   output logic cmp_two_ladder_select_o,
   output logic fixed_ref_enable_o,
   output logic cmp_pos_src_o,
   output logic cmp_neg_src_o,
   output logic conv_pos_src_o,
   output logic conv_neg_src_o,
   // Pin roles.
   output logic [1:0] shared_ref_out_pin_role_o,
   output logic ladder_reference_out_oe_o,
   output logic shared_pos_ref_pin_is_ref_o
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   logic [7:0] reference_control_reg;
   logic [7:0] reference_control_next;
   logic [vrs_pkg::SEL_W-1:0] reference_route_reg;
   logic [vrs_pkg::SEL_W-1:0] reference_route_next;
   logic [7:0] read_mux;
   logic [7:0] status_word;
   logic fixed_next;

   vrs_dec_if dec ();

   // ***************************************************************
   // Register writes
   // ***************************************************************

   // Next values feed the decoder so outputs settle on the writing edge.
   always_comb begin
      reference_control_next = reference_control_reg;
      reference_route_next = reference_route_reg;
      if (wr_i && addr_i == vrs_pkg::CTRL_ADDR) begin
         reference_control_next = wdata_i; // R11
      end
      if (wr_i && addr_i == vrs_pkg::SEL_ADDR) begin
         reference_route_next = wdata_i[vrs_pkg::SEL_W-1:0];
      end
   end

   // Every reset returns the control register to all zeros.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reference_control_reg <= vrs_pkg::CTRL_RESET; // R11
      end else begin
         reference_control_reg <= reference_control_next;
      end
   end

   // Routing register holds the comparator and converter select bits.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reference_route_reg <= vrs_pkg::SEL_RESET;
      end else begin
         reference_route_reg <= reference_route_next;
      end
   end

   // ***************************************************************
   // Decode
   // ***************************************************************
   assign dec.ctrl = reference_control_next;
   assign dec.sel = reference_route_next;

   vrs_ref_decode u_decode (
      .dec (dec.dec_mp)
   );

   // The oscillator forces the fixed reference regardless of software.
   assign fixed_next = reference_route_next[vrs_pkg::FIXED_EN_BIT] |
                       fast_internal_oscillator_i; // R12

   // Ladder controls are registered straight from the written bits, the fraction through the decoder.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ladder_power_on_o <= 1'b0;
         ladder_low_range_o <= 1'b0;
         ladder_external_source_o <= 1'b0;
         ladder_tap_select_o <= '0;
         ladder_frac_num_o <= vrs_pkg::HIGH_BASE;
      end else begin
         ladder_power_on_o <= reference_control_next[vrs_pkg::POWER_BIT]; // R7
         ladder_low_range_o <=
            reference_control_next[vrs_pkg::LOW_RANGE_BIT]; // R8
         ladder_external_source_o <=
            reference_control_next[vrs_pkg::EXT_SRC_BIT]; // R9
         ladder_tap_select_o <= reference_control_next[vrs_pkg::TAP_MSB:0];
         ladder_frac_num_o <= dec.frac; // R10
      end
   end

   // Routing outputs register the decoder and fixed_next so no glitch reaches analog.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cmp_one_ladder_select_o <= 1'b0;
         cmp_two_ladder_select_o <= 1'b0;
         divider_current_o <= 1'b0;
         fixed_ref_enable_o <= 1'b0;
         cmp_pos_src_o <= vrs_pkg::SRC_RAIL;
         cmp_neg_src_o <= vrs_pkg::SRC_RAIL;
         conv_pos_src_o <= vrs_pkg::SRC_RAIL;
         conv_neg_src_o <= vrs_pkg::SRC_RAIL;
      end else begin
         cmp_one_ladder_select_o <= dec.cmp1_ladder; // R1 R13
         cmp_two_ladder_select_o <= dec.cmp2_ladder; // R2 R13
         divider_current_o <= dec.div_current; // R3
         fixed_ref_enable_o <= fixed_next; // R12
         cmp_pos_src_o <= dec.cmp_pos; // R4
         cmp_neg_src_o <= dec.cmp_neg; // R4
         conv_pos_src_o <= dec.conv_pos; // R5
         conv_neg_src_o <= dec.conv_neg; // R5
      end
   end

   // Pin roles; the drive enable is a copy of the ladder-out role.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         shared_ref_out_pin_role_o <= vrs_pkg::PIN_IO;
         ladder_reference_out_oe_o <= 1'b0;
         shared_pos_ref_pin_is_ref_o <= 1'b0;
      end else begin
         shared_ref_out_pin_role_o <= dec.pin_role; // R6
         ladder_reference_out_oe_o <=
            (dec.pin_role == vrs_pkg::PIN_LADDER_OUT); // R6
         shared_pos_ref_pin_is_ref_o <= dec.pos_pin_ref;
      end
   end

   // ***************************************************************
   // Register reads
   // ***************************************************************

   // Status shows the block's registered state, not the written bits.
   always_comb begin
      status_word = '0;
      status_word[vrs_pkg::ST_DIV_BIT] = divider_current_o;
      status_word[vrs_pkg::ST_FIXED_BIT] = fixed_ref_enable_o;
      status_word[vrs_pkg::ST_ROLE_MSB:vrs_pkg::ST_ROLE_LSB] =
         shared_ref_out_pin_role_o;
      status_word[vrs_pkg::ST_POS_PIN_BIT] = shared_pos_ref_pin_is_ref_o;
      status_word[vrs_pkg::ST_POWER_BIT] = ladder_power_on_o;
   end

   // Unmapped addresses read as zero.
   always_comb begin
      unique case (addr_i)
         vrs_pkg::CTRL_ADDR: read_mux = reference_control_reg; // R11
         vrs_pkg::SEL_ADDR: read_mux = 8'(reference_route_reg);
         vrs_pkg::STAT_ADDR: read_mux = status_word;
         default: read_mux = vrs_pkg::READ_IDLE;
      endcase
   end

   // Read data stand for exactly one cycle after the strobe.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= vrs_pkg::READ_IDLE;
      end else if (rd_i) begin
         rdata_o <= read_mux;
      end else begin
         rdata_o <= vrs_pkg::READ_IDLE;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************

   property p_cmp_one;
      @(posedge clk_i) disable iff (!nrst_i)
      reference_route_reg[vrs_pkg::CMP1_BIT] |->
         cmp_one_ladder_select_o && divider_current_o;
   endproperty
   a_cmp_one: assert property (p_cmp_one) // R1
      else $error("Comparator one not on ladder with divider on.");

   property p_cmp_two;
      @(posedge clk_i) disable iff (!nrst_i)
      reference_route_reg[vrs_pkg::CMP2_BIT] |->
         cmp_two_ladder_select_o && divider_current_o;
   endproperty
   a_cmp_two: assert property (p_cmp_two) // R2
      else $error("Comparator two not on ladder with divider on.");

   property p_div_off;
      @(posedge clk_i) disable iff (!nrst_i)
      !reference_route_reg[vrs_pkg::CMP1_BIT] &&
      !reference_route_reg[vrs_pkg::CMP2_BIT] |->
         !divider_current_o && !cmp_one_ladder_select_o;
   endproperty
   a_div_off: assert property (p_div_off) // R3
      else $error("Divider current on with both selects clear.");

   property p_cmp_neg;
      @(posedge clk_i) disable iff (!nrst_i)
      reference_control_reg[vrs_pkg::EXT_SRC_BIT] |->
         cmp_neg_src_o == !(reference_control_reg[vrs_pkg::PIN_OUT_BIT] &&
                            !reference_route_reg[vrs_pkg::CONV_NEG_BIT]);
   endproperty
   a_cmp_neg: assert property (p_cmp_neg) // R4
      else $error("Comparator negative rail wrong.");

   property p_conv;
      @(posedge clk_i) disable iff (!nrst_i)
      wr_i && addr_i == vrs_pkg::SEL_ADDR |=>
         conv_pos_src_o == $past(wdata_i[vrs_pkg::CONV_POS_BIT]) &&
         conv_neg_src_o == $past(wdata_i[vrs_pkg::CONV_NEG_BIT]);
   endproperty
   a_conv: assert property (p_conv) // R5
      else $error("Converter rails did not follow the write.");

   property p_pin;
      @(posedge clk_i) disable iff (!nrst_i)
      reference_control_reg[vrs_pkg::PIN_OUT_BIT] &&
      !reference_route_reg[vrs_pkg::CONV_NEG_BIT] |->
         ladder_reference_out_oe_o &&
         shared_ref_out_pin_role_o == vrs_pkg::PIN_LADDER_OUT;
   endproperty
   a_pin: assert property (p_pin) // R6
      else $error("Ladder not driven onto the shared pin.");

   property p_power;
      @(posedge clk_i) disable iff (!nrst_i)
      wr_i && addr_i == vrs_pkg::CTRL_ADDR |=>
         ladder_power_on_o == $past(wdata_i[vrs_pkg::POWER_BIT]) &&
         ladder_low_range_o == $past(wdata_i[vrs_pkg::LOW_RANGE_BIT]) &&
         ladder_external_source_o == $past(wdata_i[vrs_pkg::EXT_SRC_BIT]);
   endproperty
   a_power: assert property (p_power) // R7
      else $error("Ladder controls did not follow the write.");

   property p_frac;
      @(posedge clk_i) disable iff (!nrst_i)
      ladder_frac_num_o == (ladder_low_range_o ?
         7'(ladder_tap_select_o) * 7'h04 :
         7'h18 + 7'(ladder_tap_select_o) * 7'h03);
   endproperty
   a_frac: assert property (p_frac) // R10
      else $error("Ladder fraction does not match the tap.");

   property p_readback;
      @(posedge clk_i) disable iff (!nrst_i)
      wr_i && addr_i == vrs_pkg::CTRL_ADDR ##1
      rd_i && addr_i == vrs_pkg::CTRL_ADDR |=>
         rdata_o == $past(wdata_i, 2);
   endproperty
   a_readback: assert property (p_readback) // R11
      else $error("Control register read back wrong.");

   property p_fixed;
      @(posedge clk_i) disable iff (!nrst_i)
      fast_internal_oscillator_i |=> fixed_ref_enable_o;
   endproperty
   a_fixed: assert property (p_fixed) // R12
      else $error("Fixed reference off while oscillator runs.");

endmodule : vrs_reference_select
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the reference selector.
// Assumes the host model is the only driver of the register port.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk;
   logic nrst;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic osc;
   logic pwr, lrng, esrc, div, c1, c2, fen, cpos, cneg, vpos, vneg;
   logic oe, ppin;
   logic [3:0] tap;
   logic [6:0] frac;
   logic [1:0] role;
   logic [7:0] lad_v, rt_v, pin_v, d;
   int n_errors = 0;
   int n_checks = 0;

   // ***************************************************************
   // Clock, design and host
   // ***************************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   vrs_reference_select u_vrs_reference_select (
      .clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .fast_internal_oscillator_i(osc), .ladder_power_on_o(pwr),
      .ladder_low_range_o(lrng), .ladder_external_source_o(esrc),
      .ladder_tap_select_o(tap), .ladder_frac_num_o(frac),
      .divider_current_o(div), .cmp_one_ladder_select_o(c1),
      .cmp_two_ladder_select_o(c2), .fixed_ref_enable_o(fen),
      .cmp_pos_src_o(cpos), .cmp_neg_src_o(cneg), .conv_pos_src_o(vpos),
      .conv_neg_src_o(vneg), .shared_ref_out_pin_role_o(role),
      .ladder_reference_out_oe_o(oe), .shared_pos_ref_pin_is_ref_o(ppin)
   );

   vrs_host_model u_vrs_host_model (
      .clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
      .rdata_i(rdata), .osc_o(osc)
   );

   // Outputs gathered into bytes so one compare covers a whole group.
   assign lad_v = {1'b0, pwr, lrng, esrc, tap};
   assign rt_v = {c1, c2, fen, div, cpos, cneg, vpos, vneg};
   assign pin_v = {4'h0, oe, ppin, role};

   // ***************************************************************
   // Checking helpers
   // ***************************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("Checks made %0d, mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop

   // Pin role: ladder out wins unless the converter claims the pin.
   function automatic logic [1:0] exp_role(input logic [7:0] c,
                                           input logic [7:0] r);
      if (c[6] && !r[4]) return 2'b01;
      if (r[4] || c[4]) return 2'b10;
      return 2'b00;
   endfunction : exp_role

   // Expected state after reset of every output and register.
   task automatic chk_reset;
      chk(lad_v, 8'h00);
      chk({1'b0, frac}, 8'h18);
      chk(rt_v, 8'h00);
      chk(pin_v, 8'h00);
      u_vrs_host_model.read_reg(2'h0, d);
      chk(d, 8'h00);
      u_vrs_host_model.read_reg(2'h1, d);
      chk(d, 8'h00);
   endtask : chk_reset

   // ***************************************************************
   // Watchdog
   // ***************************************************************
   // The tests take under 1,200 cycles; over sixteen times that is a hang.
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, 8'h00, 8'h01);
      report_and_stop();
   end

   // ***************************************************************
   // Tests
   // ***************************************************************
   initial begin
      logic [7:0] c, r;
      nrst = 1'b0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk_reset();
      // Every tap in both ranges, with power, pin and source bits mixed.
      for (int i = 0; i < 32; i++) begin
         c = {i[1], i[2], i[4], i[0] ^ i[3], i[3:0]};
         u_vrs_host_model.write_read(2'h0, c, d);
         chk(lad_v, {1'b0, c[7], c[5], c[4], c[3:0]});
         chk({1'b0, frac}, c[5] ? {c[3:0], 2'b00} :
             8'h18 + 8'h03 * c[3:0]);
         chk(d, c);
      end
      // All routing combinations of select, source and pin-out bits.
      for (int j = 0; j < 128; j++) begin
         r = {3'h0, j[4:0]};
         c = {1'b1, j[6], 1'b0, j[5], 4'h3};
         u_vrs_host_model.write_reg(2'h0, c);
         u_vrs_host_model.write_reg(2'h1, {3'h7, r[4:0]});
         chk(rt_v, {r[0], r[1], r[2], r[0] | r[1], c[4],
             c[4] & !(c[6] & !r[4]), r[3], r[4]});
         chk(pin_v, {4'h0, c[6] & !r[4], c[4] | r[3],
             exp_role(c, r)});
         u_vrs_host_model.read_reg(2'h1, d);
         chk(d, r);
         u_vrs_host_model.read_reg(2'h2, d);
         chk(d, {2'b00, c[7], c[4] | r[3], exp_role(c, r), r[2],
             r[0] | r[1]});
      end
      // Fast oscillator forces the fixed reference on with its bit clear.
      u_vrs_host_model.write_reg(2'h1, 8'h00);
      u_vrs_host_model.set_osc(1'b1);
      repeat (2) @(posedge clk);
      #1;
      chk({7'h0, fen}, 8'h01);
      u_vrs_host_model.set_osc(1'b0);
      repeat (2) @(posedge clk);
      #1;
      chk({7'h0, fen}, 8'h00);
      // Status and the unmapped word ignore writes; control stays put.
      u_vrs_host_model.write_reg(2'h0, 8'h9C);
      u_vrs_host_model.write_reg(2'h2, 8'hFF);
      u_vrs_host_model.write_reg(2'h3, 8'hFF);
      u_vrs_host_model.read_reg(2'h3, d);
      chk(d, 8'h00);
      u_vrs_host_model.read_reg(2'h0, d);
      chk(d, 8'h9C);
      // A reset in mid-run clears everything again.
      u_vrs_host_model.write_reg(2'h1, 8'h1F);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk_reset();
      report_and_stop();
   end
endmodule : tb
`default_nettype wire

// ===== tb/vrs_host_model.sv
// Software side of the reference selector: drives the register port.
// Assumes the bench calls its tasks from one process and owns reset.
`timescale 1ns/1ns
`default_nettype none
module vrs_host_model (
   // Clock.
   input wire logic clk_i,
   // Register port towards the block.
   output logic [vrs_pkg::ADDR_W-1:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   input wire logic [7:0] rdata_i,
   // Oscillator status.
   output logic osc_o
);
   // ***************************************************************
   // Bus cycles
   // ***************************************************************
   // Idle levels from time zero so no strobe is ever unknown.
   initial begin
      addr_o = 2'h0;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      osc_o = 1'b0;
   end

   // One-cycle write; the block updates at the edge that ends it.
   task automatic write_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      #1;
   endtask : write_reg

   // Read data stands only in the cycle after the strobe, so it is
   // captured just after the edge that takes the strobe.
   task automatic read_reg(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1;
      d = rdata_i;
   endtask : read_reg

   // Write followed by a read of the same word with no idle cycle
   // between them. This exercises the back-to-back case that the
   // separate tasks never produce, because each of them waits for
   // an edge first.
   task automatic write_read(input logic [1:0] a, input logic [7:0] dw,
                             output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= dw;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1;
      d = rdata_i;
   endtask : write_read

   // Oscillator status changes just after an edge, like the bus.
   task automatic set_osc(input logic v);
      @(posedge clk_i);
      osc_o <= v;
   endtask : set_osc
endmodule : vrs_host_model
`default_nettype wire
